/* File: rtl/rate_counter_pkg.sv */
// shared constants and types for the programmable rate display counter
package rate_counter_pkg;

  // ---------------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------------
  localparam int unsigned CMP_W   = 24;
  localparam int unsigned SW_W    = 8;
  localparam int unsigned CNT_W   = 8;
  localparam int unsigned DIGIT_W = 4;

  // ---------------------------------------------------------------------------
  // compare layout and values
  // ---------------------------------------------------------------------------
  localparam int unsigned         SW_CMP_LSB  = 11;
  localparam int unsigned         SW_CMP_MSB  = 18;
  localparam logic [CMP_W-1:0]    DEFAULT_CMP = 24'h989680;
  localparam logic [CMP_W-1:0]    CMP_ONE     = 24'h000001;

  // ---------------------------------------------------------------------------
  // reset values and fixed drive constants
  // ---------------------------------------------------------------------------
  localparam logic [CMP_W-1:0]    PRESCALE_RESET = 24'h000000;
  localparam logic [CNT_W-1:0]    COUNT_RESET    = 8'h00;
  localparam logic [SW_W-1:0]     SW_RESET       = 8'h00;
  localparam logic [SW_W-1:0]     PIN_OE_ALL     = 8'hFF;
  localparam logic [DIGIT_W-1:0]  DIGIT_BASE     = 4'hA;

  // ---------------------------------------------------------------------------
  // display carrier: segments a..g in bits 0..6, dot in bit 7
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       dot;
    logic [6:0] segs;
  } seg_t;

  localparam seg_t SEG_RESET = '{dot: 1'b0, segs: 7'h00};

endpackage

/* File: rtl/seg_decoder.sv */
// decimal digit to seven-segment pattern, active-high segments
`timescale 1ns/100ps

module seg_decoder (
  input  wire logic [3:0] digit,
  output logic      [6:0] segs
);

  always_comb begin
    case (digit)
      4'h0:    segs = 7'h3F;
      4'h1:    segs = 7'h06;
      4'h2:    segs = 7'h5B;
      4'h3:    segs = 7'h4F;
      4'h4:    segs = 7'h66;
      4'h5:    segs = 7'h6D;
      4'h6:    segs = 7'h7D;
      4'h7:    segs = 7'h07;
      4'h8:    segs = 7'h7F;
      4'h9:    segs = 7'h6F;
      // non-decimal codes blank the digit
      default: segs = 7'h00;
    endcase
  end

endmodule

/* File: rtl/rate_display_counter.sv */
// prescaled counter with switch-set compare, pin and seven-segment outputs
`timescale 1ns/100ps

// Contract
// - all-zero switches select ten million compare
// - switches fill compare bits 11 to 18
// - count advances once per prescaler match
// - low counter byte driven on pins
// - ones digit of counter shown as decimal on segments
// - reset clears prescaler and counter
module rate_display_counter (
  input  wire logic                           clk_sys,
  input  wire logic                           resetn,
  input  wire logic [7:0]                     sw_in,
  input  wire logic [7:0]                     pin_in,
  output rate_counter_pkg::seg_t              seg_out,
  output logic      [7:0]                     pin_out,
  output logic      [7:0]                     pin_oe
);

  // ---------------------------------------------------------------------------
  // switch synchroniser
  // ---------------------------------------------------------------------------
  logic [rate_counter_pkg::SW_W-1:0]    sw_meta_r;
  logic [rate_counter_pkg::SW_W-1:0]    sw_sync_r;
  logic [rate_counter_pkg::CMP_W-1:0]   cmp_r;
  logic [rate_counter_pkg::CMP_W-1:0]   cmp_nxt;
  logic [rate_counter_pkg::CMP_W-1:0]   prescale_r;
  logic [rate_counter_pkg::CNT_W-1:0]   count_r;
  logic [rate_counter_pkg::DIGIT_W-1:0] ones_digit;
  logic [6:0]                           segs_nxt;
  logic                                 tick;
  logic                                 dot_nxt;
  rate_counter_pkg::seg_t               seg_r;

  // switches are loose pins, so two flops before anything reads them
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sw_meta_r <= rate_counter_pkg::SW_RESET;
      sw_sync_r <= rate_counter_pkg::SW_RESET;
    end else begin
      sw_meta_r <= sw_in;
      sw_sync_r <= sw_meta_r;
    end
  end

  // ---------------------------------------------------------------------------
  // compare register
  // ---------------------------------------------------------------------------
  always_comb begin
    cmp_nxt = '0;
    if (sw_sync_r == rate_counter_pkg::SW_RESET) begin
      cmp_nxt = rate_counter_pkg::DEFAULT_CMP;
    end else begin
      cmp_nxt[rate_counter_pkg::SW_CMP_MSB:rate_counter_pkg::SW_CMP_LSB] = sw_sync_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cmp_r <= rate_counter_pkg::DEFAULT_CMP;
    end else begin
      cmp_r <= cmp_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // prescaler and counter
  // ---------------------------------------------------------------------------
  // >= rather than == so a compare lowered below the running prescale
  // restarts at once instead of wrapping through all 2^24 states
  assign tick = (prescale_r >= (cmp_r - rate_counter_pkg::CMP_ONE));

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      prescale_r <= rate_counter_pkg::PRESCALE_RESET;
    end else if (tick) begin
      prescale_r <= rate_counter_pkg::PRESCALE_RESET;
    end else begin
      prescale_r <= prescale_r + rate_counter_pkg::CMP_ONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      count_r <= rate_counter_pkg::COUNT_RESET;
    end else if (tick) begin
      count_r <= count_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------------------
  // pin_in is unused: the bidirectional lines are outputs only
  assign pin_out = count_r;
  assign pin_oe  = rate_counter_pkg::PIN_OE_ALL;

  // ---------------------------------------------------------------------------
  // decimal display
  // ---------------------------------------------------------------------------
  // one digit only, so just the ones place of the count is shown
  assign ones_digit = rate_counter_pkg::DIGIT_W'(count_r % rate_counter_pkg::DIGIT_BASE);
  // dot lit for the first half of each count period as a pace indicator
  assign dot_nxt    = (prescale_r < (cmp_r >> 1));

  seg_decoder u_seg_decoder (
    .digit (ones_digit),
    .segs  (segs_nxt)
  );

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      seg_r <= rate_counter_pkg::SEG_RESET;
    end else begin
      seg_r <= '{dot: dot_nxt, segs: segs_nxt};
    end
  end

  assign seg_out = seg_r;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_default_compare: assert property (
    (sw_sync_r == 8'h00) |=> (cmp_r == 24'h989680))
    else $error("default compare not loaded");

  a_switch_compare: assert property (
    (sw_sync_r != 8'h00) |=> (cmp_r == {5'h00, $past(sw_sync_r), 11'h000}))
    else $error("switch compare layout wrong");

  a_count_step: assert property (
    tick |=> (count_r == $past(count_r) + 8'h01))
    else $error("counter did not advance on match");

  a_count_hold: assert property (
    !tick |=> $stable(count_r))
    else $error("counter moved without match");

  a_pins_follow: assert property (
    tick |=> (pin_out == $past(pin_out) + 8'h01) && (pin_oe == 8'hFF))
    else $error("pins do not carry counter");

  a_seg_zero: assert property (
    ((count_r % 8'h0A) == 8'h00) |=> (seg_out.segs == 7'h3F))
    else $error("segment pattern wrong for zero digit");

  // ---------------------------------------------------------------------------
  // glyph table, one check per nonzero decimal digit
  // ---------------------------------------------------------------------------
  a_seg_one: assert property (
    ((count_r % 8'h0A) == 8'h01) |=> (seg_out.segs == 7'h06))
    else $error("segment pattern wrong for digit one");

  a_seg_two: assert property (
    ((count_r % 8'h0A) == 8'h02) |=> (seg_out.segs == 7'h5B))
    else $error("segment pattern wrong for digit two");

  a_seg_three: assert property (
    ((count_r % 8'h0A) == 8'h03) |=> (seg_out.segs == 7'h4F))
    else $error("segment pattern wrong for digit three");

  a_seg_four: assert property (
    ((count_r % 8'h0A) == 8'h04) |=> (seg_out.segs == 7'h66))
    else $error("segment pattern wrong for digit four");

  a_seg_five: assert property (
    ((count_r % 8'h0A) == 8'h05) |=> (seg_out.segs == 7'h6D))
    else $error("segment pattern wrong for digit five");

  a_seg_six: assert property (
    ((count_r % 8'h0A) == 8'h06) |=> (seg_out.segs == 7'h7D))
    else $error("segment pattern wrong for digit six");

  a_seg_seven: assert property (
    ((count_r % 8'h0A) == 8'h07) |=> (seg_out.segs == 7'h07))
    else $error("segment pattern wrong for digit seven");

  a_seg_eight: assert property (
    ((count_r % 8'h0A) == 8'h08) |=> (seg_out.segs == 7'h7F))
    else $error("segment pattern wrong for digit eight");

  a_seg_nine: assert property (
    ((count_r % 8'h0A) == 8'h09) |=> (seg_out.segs == 7'h6F))
    else $error("segment pattern wrong for digit nine");

  // dot is still low after the match edge and comes back one edge later
  a_dot_pace: assert property (
    tick |=> !seg_out.dot ##1 seg_out.dot)
    else $error("dot does not follow the count period");

  // a lowered compare is only seen one edge later, hence the past value
  a_prescale_bound: assert property (
    (prescale_r < cmp_r) |=> (prescale_r < $past(cmp_r)))
    else $error("prescaler ran past the compare value");

  // two edges from pin to synchronised copy once reset has settled
  a_sync_depth: assert property (
    $past(resetn, 2) && $past(resetn) |-> (sw_sync_r == $past(sw_in, 2)))
    else $error("switch synchroniser depth wrong");

  // compare comes back to the default however the switches stand
  a_compare_reset: assert property (@(posedge clk_sys) disable iff (1'b0)
    !resetn |=> (cmp_r == 24'h989680))
    else $error("reset did not restore default compare");

  a_reset_clear: assert property (@(posedge clk_sys) disable iff (1'b0)
    !resetn |=> (prescale_r == 24'h000000) && (count_r == 8'h00))
    else $error("reset did not clear counters");

  a_prescale_restart: assert property (
    tick |=> (prescale_r == 24'h000000) ##1 (prescale_r <= 24'h000001))
    else $error("prescaler did not restart on match");

  c_default_tick: cover property ((cmp_r == 24'h989680) && tick);
  c_switch_tick:  cover property ((sw_sync_r != 8'h00) && tick);
  c_count_wrap:   cover property ((count_r == 8'hFF) && tick);
  c_compare_move: cover property ($changed(cmp_r));

endmodule

/* File: tb/board_model.sv */
// switch bank and seven-segment display on the board side
`timescale 1ns/100ps

module board_model (
  input  wire logic [7:0]             sw_set,
  input  wire rate_counter_pkg::seg_t seg_out,
  output logic      [7:0]             sw_in,
  output logic      [3:0]             digit
);
  // switches are plain levels, bounce not modelled
  assign sw_in = sw_set;

  // unknown patterns read as F so a bad glyph never matches a digit
  always_comb begin
    case (seg_out.segs)
      7'h3F: digit = 4'h0;
      7'h06: digit = 4'h1;
      7'h5B: digit = 4'h2;
      7'h4F: digit = 4'h3;
      7'h66: digit = 4'h4;
      7'h6D: digit = 4'h5;
      7'h7D: digit = 4'h6;
      7'h07: digit = 4'h7;
      7'h7F: digit = 4'h8;
      7'h6F: digit = 4'h9;
      default: digit = 4'hF;
    endcase
  end
endmodule

/* File: tb/rate_display_counter_tb.sv */
// self-checking bench for the rate display counter
`timescale 1ns/100ps

module rate_display_counter_tb;
  logic                   clk_sys = 1'b0;
  logic                   resetn  = 1'b0;
  logic [7:0]             sw_set  = 8'h00;
  logic [7:0]             pin_in  = 8'h00;
  logic [7:0]             sw_in;
  logic [7:0]             pin_out;
  logic [7:0]             pin_oe;
  logic [3:0]             digit;
  rate_counter_pkg::seg_t seg_out;
  logic [15:0]            lfsr_r  = 16'h0041;
  logic [7:0]             exp_cnt = 8'h00;
  logic [7:0]             sw_tab [4];
  int                     mismatches = 0;
  int                     cmp_count = 0;
  int                     n;

  always #50 clk_sys = ~clk_sys;

  rate_display_counter dut (.clk_sys(clk_sys), .resetn(resetn), .sw_in(sw_in),
    .pin_in(pin_in), .seg_out(seg_out), .pin_out(pin_out), .pin_oe(pin_oe));
  board_model board (.sw_set(sw_set), .seg_out(seg_out), .sw_in(sw_in), .digit(digit));

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input int cyc);
    @(posedge clk_sys);
    #10 resetn = 1'b0;
    repeat (cyc) @(posedge clk_sys);
    #10 resetn = 1'b1;
    exp_cnt = 8'h00;
  endtask

  // waits for one increment, then checks pins and display; n counts edges
  task automatic wait_step(output int cnt);
    logic [7:0] prev;
    prev = pin_out;
    cnt = 0;
    while (pin_out === prev && cnt < 20000) begin
      @(posedge clk_sys);
      #10 lfsr_r = lfsr_next(lfsr_r);
      pin_in = lfsr_r[15:8];
      cnt++;
    end
    exp_cnt = exp_cnt + 8'h01;
    check(pin_out, exp_cnt);
    check(seg_out.dot, 1'b0);
    @(posedge clk_sys);
    #10 check(digit, exp_cnt % 10);
    check(seg_out.dot, 1'b1);
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    #10 resetn = 1'b1;
    check(pin_oe, 8'hFF);
    check(pin_out, 8'h00);
    // default compare is far longer than this span
    repeat (10000) @(posedge clk_sys);
    #10 check(pin_out, 8'h00);
    check(seg_out, 8'hBF);
    sw_tab[0] = 8'h01;
    sw_tab[1] = 8'h02;
    for (int i = 2; i < 4; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      sw_tab[i] = {6'h00, lfsr_r[1:0]} | 8'h01;
    end
    foreach (sw_tab[i]) begin
      sw_set = sw_tab[i];
      // first step may be short after a compare change
      wait_step(n);
      wait_step(n);
      check(n + 1, {5'h00, sw_tab[i], 11'h000});
    end
    do_reset(3);
    check(pin_out, 8'h00);
    wait_step(n);
    wait_step(n);
    check(n + 1, {5'h00, sw_set, 11'h000});
    tally_and_finish();
  end

  // worst mix of periods is near 57k cycles; stop at 90k, under the run budget
  initial begin
    #9000000;
    mismatches++;
    tally_and_finish();
  end
endmodule
